// File: src/stm_monitor.sv
// Supply, thermal and wake-up fault monitor with interface mode selection.
// Assumes comparator and pin inputs are asynchronous; reads of the flag register arrive as
// a one-cycle pulse from the serial port logic on this clock.
//
// Behaviour
// - Supply low and undervoltage monitoring only in serial-configured mode.
// - Supply below low-voltage threshold sets supply_low_warn status.
// - With warn enable set, low warning also sets its flag and irq_fault.
// - Supply below lockout sets supply_uv status, its flag and irq_fault.
// - No control can disable undervoltage monitoring or its interrupt.
// - Wake-up recognised when line stays shorted 80 us, any driver configuration.
// - On wake-up, wake_out pulses low for 200 us.
// - Serial mode wake-up sets wake_irq and asserts irq_fault.
// - Serial mode wake_disable suppresses wake-up; pin mode always detects.
// - Wake detection blanked 128 us in pin mode, selectable in serial mode.
// - Serial mode over 140 C sets temp_warn, its flag and irq_fault.
// - temp_warn clears at 125 C; flag and irq hold until flags read.
// - Pin mode raises no overtemperature warning.
// - Over 165 C the line driver and both regulators switch off.
// - Serial configuration port stays operational during thermal shutdown.
// - Serial mode thermal shutdown sets therm_shut status and its flag.
// - Regulators restart after cooling; internal 5V use resets configuration.
// - Mux mode 0: with uart_select high, chip_sel_pp low gives SPI, high gives UART; uart_select low enables both.
// - Mux mode 1: uart_select chooses UART or SPI on shared pins.
// - Mux mode 1: transmit pins sampled on falling edge of uart_select.
`timescale 1ns/1ns
module stm_monitor #(
	parameter int WAKE_SHORT_CYC = stm_pkg::WAKE_SHORT_CYC,
	parameter int WAKE_PULSE_CYC = stm_pkg::WAKE_PULSE_CYC,
	parameter int BLANK_PIN_CYC  = stm_pkg::BLANK_PIN_CYC,
	parameter int BLANK_CYC_0    = stm_pkg::BLANK_SEL0_US * stm_pkg::CLK_MHZ,
	parameter int BLANK_CYC_1    = stm_pkg::BLANK_SEL1_US * stm_pkg::CLK_MHZ,
	parameter int BLANK_CYC_2    = stm_pkg::BLANK_SEL2_US * stm_pkg::CLK_MHZ,
	parameter int BLANK_CYC_3    = stm_pkg::BLANK_SEL3_US * stm_pkg::CLK_MHZ
) (
	input  wire logic       clock_in,
	input  wire logic       srst_in,
	input  wire logic       serial_mode_in,
	input  wire logic       uart_select_in,
	input  wire logic       chip_sel_pp_in,
	input  wire logic       mux_sel_mode_in,
	input  wire logic       shared_in_tx_in,
	input  wire logic       shared_clk_txen_in,
	input  wire logic       supply_low_cmp_in,
	input  wire logic       supply_uv_cmp_in,
	input  wire logic       temp_warn_cmp_in,
	input  wire logic       temp_shut_cmp_in,
	input  wire logic       line_short_cmp_in,
	input  wire logic       driver_on_in,
	input  wire logic       supply_low_warn_enable_in,
	input  wire logic       wake_disable_in,
	input  wire logic       blank_sel_lo_in,
	input  wire logic       blank_sel_hi_in,
	input  wire logic       int5v_used_in,
	input  wire logic       irq_read_in,
	output logic [7:0]      irq_flags_out,
	output logic            supply_low_warn_out,
	output logic            supply_uv_out,
	output logic            temp_warn_out,
	output logic            therm_shut_out,
	output logic            irq_fault_n_out,
	output logic            wake_n_out,
	output logic            driver_off_out,
	output logic            regulators_off_out,
	output logic            config_reset_out,
	output logic            spi_active_out,
	output logic            uart_active_out,
	output logic            tx_data_out,
	output logic            tx_en_out
);
	////////////////////////////////////////////////////////////////////////////////////
	// Synchronisers for every asynchronous level.

	localparam int NSYNC = 10;
	logic [NSYNC-1:0] raw;
	logic [NSYNC-1:0] syn;
	assign raw = {supply_low_cmp_in, supply_uv_cmp_in, temp_warn_cmp_in, temp_shut_cmp_in,
	              line_short_cmp_in, serial_mode_in, uart_select_in, chip_sel_pp_in,
	              shared_in_tx_in, shared_clk_txen_in};

	stm_sync #(.W(NSYNC)) u_sync (
		.clock_in (clock_in),
		.srst_in  (srst_in),
		.async_in (raw),
		.sync_out (syn)
	);

	logic low_s;
	logic uv_s;
	logic tw_s;
	logic ts_s;
	logic short_s;
	logic serial_s;
	logic usel_s;
	logic cs_s;
	logic tx_s;
	logic txen_s;
	assign {low_s, uv_s, tw_s, ts_s, short_s, serial_s, usel_s, cs_s, tx_s, txen_s} = syn;

	////////////////////////////////////////////////////////////////////////////////////
	// Interface mode selection.

	stm_pkg::stm_mode_t mode;
	always_comb begin
		if (!serial_s)
			mode = stm_pkg::STM_PIN;
		else if (!usel_s && !mux_sel_mode_in)
			mode = stm_pkg::STM_PAR;
		else if (!mux_sel_mode_in)
			mode = stm_pkg::STM_MUXC;
		else
			mode = stm_pkg::STM_MUXU;
	end

	always_comb begin
		unique case (mode)
			stm_pkg::STM_PIN: begin
				spi_active_out  = 1'b0;
				uart_active_out = 1'b1;
			end
			stm_pkg::STM_PAR: begin
				spi_active_out  = 1'b1;
				uart_active_out = 1'b1;
			end
			stm_pkg::STM_MUXC: begin
				spi_active_out  = !cs_s;
				uart_active_out = cs_s;
			end
			stm_pkg::STM_MUXU: begin
				spi_active_out  = !usel_s;
				uart_active_out = usel_s;
			end
		endcase
	end

	// In mux mode 1 the transmit pins are latched when uart_select falls so the line never sees the SPI
	// traffic that follows on the shared pins.
	logic usel_prev_q;
	always_ff @(posedge clock_in) begin
		if (srst_in)
			usel_prev_q <= 1'b0;
		else
			usel_prev_q <= usel_s;
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			tx_data_out <= 1'b1;
			tx_en_out   <= 1'b0;
		end else if (mode == stm_pkg::STM_MUXU) begin
			if (usel_prev_q && !usel_s) begin
				tx_data_out <= tx_s;
				tx_en_out   <= txen_s;
			end
		end else begin
			tx_data_out <= tx_s;
			tx_en_out   <= txen_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////
	// Status bits.

	logic serial_on;
	assign serial_on = (mode != stm_pkg::STM_PIN);

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			supply_low_warn_out <= 1'b0;
			supply_uv_out       <= 1'b0;
			temp_warn_out       <= 1'b0;
			therm_shut_out      <= 1'b0;
		end else begin
			supply_low_warn_out <= serial_on && low_s;
			supply_uv_out       <= serial_on && uv_s;
			// The comparator carries the 140/125 C hysteresis itself.
			temp_warn_out       <= serial_on && tw_s;
			therm_shut_out      <= serial_on && ts_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////
	// Thermal shutdown and restart.

	logic ts_prev_q;
	always_ff @(posedge clock_in) begin
		if (srst_in)
			ts_prev_q <= 1'b0;
		else
			ts_prev_q <= ts_s;
	end

	// Driver and regulators follow the shutdown comparator in every mode; the serial
	// port logic is not gated, so configuration access survives shutdown.
	assign driver_off_out     = ts_s;
	assign regulators_off_out = ts_s;
	assign config_reset_out   = ts_prev_q && !ts_s && int5v_used_in;

	////////////////////////////////////////////////////////////////////////////////////
	// Wake-up detection.

	logic [stm_pkg::CNT_W-1:0] blank_cyc;
	always_comb begin
		if (mode == stm_pkg::STM_PIN)
			blank_cyc = stm_pkg::CNT_W'(BLANK_PIN_CYC);
		else begin
			unique case ({blank_sel_hi_in, blank_sel_lo_in})
				2'b00: blank_cyc = stm_pkg::CNT_W'(BLANK_CYC_0);
				2'b01: blank_cyc = stm_pkg::CNT_W'(BLANK_CYC_1);
				2'b10: blank_cyc = stm_pkg::CNT_W'(BLANK_CYC_2);
				2'b11: blank_cyc = stm_pkg::CNT_W'(BLANK_CYC_3);
			endcase
		end
	end

	logic wake_en;
	assign wake_en = (mode == stm_pkg::STM_PIN) || !wake_disable_in;

	stm_pkg::stm_wake_t        wst_q;
	logic [stm_pkg::CNT_W-1:0] wcnt_q;
	logic                      wake_evt;
	assign wake_evt = (wst_q == stm_pkg::STM_SHORT) && short_s &&
	                  (wcnt_q == stm_pkg::CNT_W'(WAKE_SHORT_CYC - 1));

	// Any driver configuration is covered: the short comparator fires on overcurrent
	// whether the stage is push-pull, high-side or low-side.
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			wst_q  <= stm_pkg::STM_IDLE;
			wcnt_q <= '0;
		end else begin
			unique case (wst_q)
				stm_pkg::STM_IDLE: begin
					wcnt_q <= '0;
					if (wake_en && driver_on_in && short_s)
						wst_q <= stm_pkg::STM_BLANK;
				end
				stm_pkg::STM_BLANK: begin
					if (!short_s || !wake_en) begin
						wst_q <= stm_pkg::STM_IDLE;
					end else if (wcnt_q == blank_cyc - 1'b1) begin
						wst_q  <= stm_pkg::STM_SHORT;
						wcnt_q <= '0;
					end else
						wcnt_q <= wcnt_q + 1'b1;
				end
				stm_pkg::STM_SHORT: begin
					if (!short_s || !wake_en) begin
						wst_q <= stm_pkg::STM_IDLE;
					end else if (wake_evt) begin
						wst_q  <= stm_pkg::STM_PULSE;
						wcnt_q <= '0;
					end else
						wcnt_q <= wcnt_q + 1'b1;
				end
				stm_pkg::STM_PULSE: begin
					if (wcnt_q == stm_pkg::CNT_W'(WAKE_PULSE_CYC - 1)) begin
						wst_q  <= stm_pkg::STM_IDLE;
						wcnt_q <= '0;
					end else
						wcnt_q <= wcnt_q + 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in)
			wake_n_out <= 1'b1;
		else
			wake_n_out <= !(wake_evt || (wst_q == stm_pkg::STM_PULSE &&
			              wcnt_q != stm_pkg::CNT_W'(WAKE_PULSE_CYC - 1)));
	end

	////////////////////////////////////////////////////////////////////////////////////
	// Latched interrupt flags; a new event wins over a read in the same cycle.

	logic [7:0] set_d;
	always_comb begin
		set_d = 8'h00;
		set_d[stm_stm_bits(stm_pkg::IRQ_LOW_BIT)]  = serial_on && low_s && !supply_low_warn_out
		                                            && supply_low_warn_enable_in;
		set_d[stm_stm_bits(stm_pkg::IRQ_UV_BIT)]   = serial_on && uv_s && !supply_uv_out;
		set_d[stm_stm_bits(stm_pkg::IRQ_TEMP_BIT)] = serial_on && tw_s && !temp_warn_out;
		set_d[stm_stm_bits(stm_pkg::IRQ_SHUT_BIT)] = serial_on && ts_s && !therm_shut_out;
		set_d[stm_stm_bits(stm_pkg::IRQ_WAKE_BIT)] = serial_on && wake_evt;
	end

	function automatic logic [2:0] stm_stm_bits(input int b);
		stm_stm_bits = b[2:0];
	endfunction : stm_stm_bits

	always_ff @(posedge clock_in) begin
		if (srst_in)
			irq_flags_out <= stm_pkg::IRQ_RST;
		else if (irq_read_in)
			irq_flags_out <= set_d;
		else
			irq_flags_out <= irq_flags_out | set_d;
	end

	assign irq_fault_n_out = ~|irq_flags_out;
endmodule : stm_monitor

// File: src/stm_pkg.sv
// Package of the supply, thermal and wake-up monitor: constants and types.
// Assumes a 50 MHz logic clock; wake and pin-mode blanking times are converted to cycle counts here, serial blanking choices in stm_monitor.
package stm_pkg;
	localparam int CLK_MHZ          = 50;
	localparam int WAKE_SHORT_US    = 80;
	localparam int WAKE_PULSE_US    = 200;
	localparam int BLANK_PIN_US     = 128;
	localparam int WAKE_SHORT_CYC   = WAKE_SHORT_US * CLK_MHZ;
	localparam int WAKE_PULSE_CYC   = WAKE_PULSE_US * CLK_MHZ;
	localparam int BLANK_PIN_CYC    = BLANK_PIN_US * CLK_MHZ;
	// Blanking choices for the serial-configured mode, selected by two bits.
	localparam int BLANK_SEL0_US    = 128;
	localparam int BLANK_SEL1_US    = 256;
	localparam int BLANK_SEL2_US    = 512;
	localparam int BLANK_SEL3_US    = 1024;
	localparam int CNT_W            = 16;

	// Interrupt flag bit positions.
	localparam int IRQ_TEMP_BIT     = 0;
	localparam int IRQ_UV_BIT       = 2;
	localparam int IRQ_LOW_BIT      = 3;
	localparam int IRQ_WAKE_BIT     = 6;
	localparam int IRQ_SHUT_BIT     = 7;
	localparam logic [7:0] IRQ_RST  = 8'h00;

	typedef enum logic [1:0] {
		STM_PIN  = 2'b00,
		STM_PAR  = 2'b01,
		STM_MUXC = 2'b10,
		STM_MUXU = 2'b11
	} stm_mode_t;

	typedef enum logic [1:0] {
		STM_IDLE  = 2'b00,
		STM_BLANK = 2'b01,
		STM_SHORT = 2'b10,
		STM_PULSE = 2'b11
	} stm_wake_t;
endpackage : stm_pkg

// File: src/stm_sync.sv
// Two-flop synchroniser for a vector of asynchronous levels.
// Assumes inputs are quasi-static comparator levels; no bus coherency.
`timescale 1ns/1ns
module stm_sync #(
	parameter int W = 1
) (
	input  wire logic         clock_in,
	input  wire logic         srst_in,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : stm_sync

// File: tb/stm_monitor_assertions.sv
// Checker of the monitor: properties on the top ports only.
// Assumes it is bound to stm_monitor with the same wake pulse length.
`timescale 1ns/1ns
module stm_monitor_assertions #(
	parameter int WAKE_PULSE_CYC = 10
) (
	input wire logic       clock_in,
	input wire logic       srst_in,
	input wire logic       serial_mode_in,
	input wire logic       temp_shut_cmp_in,
	input wire logic       supply_low_warn_enable_in,
	input wire logic       int5v_used_in,
	input wire logic       irq_read_in,
	input wire logic [7:0] irq_flags_out,
	input wire logic       supply_uv_out,
	input wire logic       irq_fault_n_out,
	input wire logic       wake_n_out,
	input wire logic       driver_off_out,
	input wire logic       regulators_off_out,
	input wire logic       config_reset_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (srst_in);
	////////////////////////////////
	// Counting low cycles checks the pulse length at any parameter value.
	int low_q;
	always_ff @(posedge clock_in) begin
		low_q <= (srst_in || wake_n_out) ? 0 : low_q + 1;
	end
	a_irq_pin_any: assert property (irq_fault_n_out == !(|irq_flags_out))
		else $error("irq pin disagrees with flags");
	a_uv_flag_set: assert property ($rose(supply_uv_out) |-> irq_flags_out[2])
		else $error("uv status without flag");
	a_uv_serial_only: assert property ($rose(supply_uv_out) |->
		$past(serial_mode_in, 2) || $past(serial_mode_in, 3))
		else $error("uv status in pin mode");
	a_low_needs_en: assert property ($rose(irq_flags_out[3]) |->
		$past(supply_low_warn_enable_in))
		else $error("low flag while disabled");
	a_temp_flag_hold: assert property (irq_flags_out[0] && !irq_read_in |=> irq_flags_out[0])
		else $error("temp flag lost before read");
	a_wake_pulse_len: assert property ($rose(wake_n_out) |-> low_q == WAKE_PULSE_CYC)
		else $error("wake pulse length wrong");
	a_shut_turns_off: assert property (temp_shut_cmp_in [*3] |=>
		driver_off_out && regulators_off_out)
		else $error("shutdown did not switch off");
	a_cfg_rst_pulse: assert property (config_reset_out |->
		$past(int5v_used_in) ##1 !config_reset_out)
		else $error("config reset pulse wrong");
endmodule : stm_monitor_assertions

// File: tb/stm_host_model.sv
// Host model: one-cycle flag reads and the mode select pin.
// Assumes requests come from the bench just after a clock edge.
`timescale 1ns/1ns
module stm_host_model (
	input  wire logic clock_in,
	input  wire logic rd_req_in,
	input  wire logic sel_in,
	output logic      irq_read_out,
	output logic      uart_select_out
);
	// A held strobe would clear flags raised later, so reads last one cycle.
	always_ff @(posedge clock_in) begin
		irq_read_out <= rd_req_in && !irq_read_out;
	end
	always_ff @(posedge clock_in) begin
		uart_select_out <= sel_in;
	end
endmodule : stm_host_model

// File: tb/tb_stm_monitor.sv
// Testbench of the monitor against an expected-flag model.
// Assumes shortened counts; the host model performs flag reads.
`timescale 1ns/1ns
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin bad_count++; \
	$display("BAD %s exp %0h got %0h", n, e, s); end end
module tb_stm_monitor;
	logic clock_in = 1'b0;
	logic srst_in = 1'b1;
	logic serial_mode_in, chip_sel_pp_in, mux_sel_mode_in, shared_in_tx_in, shared_clk_txen_in;
	logic supply_low_cmp_in, supply_uv_cmp_in, temp_warn_cmp_in, temp_shut_cmp_in;
	logic line_short_cmp_in, driver_on_in, supply_low_warn_enable_in, wake_disable_in;
	logic blank_sel_lo_in, blank_sel_hi_in, int5v_used_in, uart_select_in, irq_read_in;
	logic rd_req, sel;
	logic [7:0] irq_flags_out;
	logic supply_low_warn_out, supply_uv_out, temp_warn_out, therm_shut_out, irq_fault_n_out;
	logic wake_n_out, driver_off_out, regulators_off_out, config_reset_out, spi_active_out;
	logic uart_active_out, tx_data_out, tx_en_out;
	int bad_count = 0;
	int check_count = 0;
	int exp_fl = 0;
	int n;
	int cyc_n = 0;
	always #10 clock_in = ~clock_in;
	stm_monitor #(.WAKE_SHORT_CYC(8), .WAKE_PULSE_CYC(10), .BLANK_PIN_CYC(4), .BLANK_CYC_0(4),
		.BLANK_CYC_1(4), .BLANK_CYC_2(4), .BLANK_CYC_3(4)) dut_u (.*);
	stm_host_model host_u (.clock_in(clock_in), .rd_req_in(rd_req), .sel_in(sel),
		.irq_read_out(irq_read_in), .uart_select_out(uart_select_in));
	////////////////////////////////
	task automatic cyc(input int k);
		repeat (k) @(posedge clock_in);
		#1;
	endtask : cyc
	task automatic rd();
		rd_req = 1'b1;
		cyc(1);
		rd_req = 1'b0;
		cyc(2);
		exp_fl = 0;
	endtask : rd
	task automatic fl();
		`CHK("flags", exp_fl[7:0], irq_flags_out)
		`CHK("irq_n", exp_fl == 0, irq_fault_n_out)
	endtask : fl
	task automatic wake(input logic hit, input int bit6);
		{blank_sel_hi_in, blank_sel_lo_in} = 2'($urandom);
		line_short_cmp_in = 1'b1;
		for (n = 0; n < 40 && wake_n_out !== 1'b0; n++) cyc(1);
		line_short_cmp_in = 1'b0;
		`CHK("wake_n", !hit, wake_n_out)
		cyc(12);
		exp_fl |= bit6 << 6;
		fl();
	endtask : wake
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test
	always @(posedge clock_in) begin
		cyc_n++;
		if (cyc_n == 3000) begin
			bad_count++;
			end_of_test();
		end
	end
	////////////////////////////////
	initial begin
		{serial_mode_in, chip_sel_pp_in, mux_sel_mode_in, shared_in_tx_in, shared_clk_txen_in,
			supply_low_cmp_in, supply_uv_cmp_in, temp_warn_cmp_in, temp_shut_cmp_in,
			line_short_cmp_in, driver_on_in, supply_low_warn_enable_in, wake_disable_in,
			blank_sel_lo_in, blank_sel_hi_in, int5v_used_in, rd_req} = '0;
		sel = 1'b1;
		n = $urandom(32'he9e9);
		cyc(5);
		srst_in = 1'b0;
		`CHK("tx", 2'b10, {tx_data_out, tx_en_out})
		fl();
		serial_mode_in = 1'b1;
		driver_on_in = 1'b1;
		int5v_used_in = 1'b1;
		cyc(4);
		{supply_uv_cmp_in, supply_low_cmp_in, temp_warn_cmp_in} = 3'b111;
		cyc(5);
		exp_fl = 8'h05;
		`CHK("status", 3'b111, {supply_uv_out, supply_low_warn_out, temp_warn_out})
		fl();
		{supply_low_cmp_in, temp_warn_cmp_in, supply_low_warn_enable_in} = 3'b001;
		cyc(5);
		`CHK("temp_warn", 1'b0, temp_warn_out)
		fl();
		supply_low_cmp_in = 1'b1;
		cyc(5);
		exp_fl |= 8;
		fl();
		rd();
		fl();
		{supply_uv_cmp_in, supply_low_cmp_in, temp_shut_cmp_in} = 3'b001;
		cyc(5);
		exp_fl = 8'h80;
		`CHK("shut", 3'b111, {driver_off_out, regulators_off_out, therm_shut_out})
		fl();
		rd();
		fl();
		temp_shut_cmp_in = 1'b0;
		for (n = 0; n < 8 && config_reset_out !== 1'b1; n++) cyc(1);
		`CHK("cfg_reset", 1'b1, config_reset_out)
		// With an external 5V supply the restart must leave the configuration alone.
		int5v_used_in = 1'b0;
		temp_shut_cmp_in = 1'b1;
		cyc(5);
		rd();
		temp_shut_cmp_in = 1'b0;
		n = 0;
		repeat (6) begin
			cyc(1);
			n |= config_reset_out;
		end
		`CHK("cfg_keep", 0, n)
		int5v_used_in = 1'b1;
		// A short with the driver switched off is not a wake-up.
		driver_on_in = 1'b0;
		wake(1'b0, 0);
		driver_on_in = 1'b1;
		cyc(4);
		wake(1'b1, 1);
		rd();
		wake_disable_in = 1'b1;
		wake(1'b0, 0);
		serial_mode_in = 1'b0;
		cyc(4);
		wake(1'b1, 0);
		{temp_warn_cmp_in, supply_uv_cmp_in} = 2'b11;
		cyc(5);
		`CHK("pin_status", 2'b00, {temp_warn_out, supply_uv_out})
		fl();
		serial_mode_in = 1'b1;
		for (int i = 0; i < 8; i++) begin
			{mux_sel_mode_in, sel, chip_sel_pp_in} = 3'(i);
			cyc(4);
			`CHK("spi", mux_sel_mode_in ? !sel : (sel ? !chip_sel_pp_in : 1'b1), spi_active_out)
			`CHK("uart", mux_sel_mode_in ? sel : (sel ? chip_sel_pp_in : 1'b1), uart_active_out)
		end
		n = $urandom;
		{shared_in_tx_in, shared_clk_txen_in} = {n[0], 1'b1};
		cyc(3);
		sel = 1'b0;
		cyc(6);
		`CHK("tx_fall", {n[0], 1'b1}, {tx_data_out, tx_en_out})
		{shared_in_tx_in, shared_clk_txen_in} = {!n[0], 1'b0};
		cyc(6);
		`CHK("tx_hold", {n[0], 1'b1}, {tx_data_out, tx_en_out})
		end_of_test();
	end
endmodule : tb_stm_monitor
bind stm_monitor stm_monitor_assertions #(.WAKE_PULSE_CYC(WAKE_PULSE_CYC)) chk_u (
	.clock_in(clock_in), .srst_in(srst_in), .serial_mode_in(serial_mode_in),
	.temp_shut_cmp_in(temp_shut_cmp_in), .int5v_used_in(int5v_used_in),
	.supply_low_warn_enable_in(supply_low_warn_enable_in), .irq_read_in(irq_read_in),
	.irq_flags_out(irq_flags_out), .supply_uv_out(supply_uv_out), .wake_n_out(wake_n_out),
	.irq_fault_n_out(irq_fault_n_out), .driver_off_out(driver_off_out),
	.regulators_off_out(regulators_off_out), .config_reset_out(config_reset_out));
